// ===== control_pin_mode_decoder_tb.sv
`timescale 1ns/10ps
`default_nettype none
module control_pin_mode_decoder_tb;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic cal = 1'b0;
  logic ac = 1'b0;
  logic [7:0] fs_exp = cpm_pkg::FS_ADJ_RST;
  logic [31:0] rnd;
  logic [31:0] rd_val;
  logic [31:0] rdata_o;
  cpm_pkg::cpm_pins_t cfg = '0;
  cpm_pkg::cpm_pins_t pins;
  cpm_pkg::cpm_bus_req_t bus = '0;
  cpm_pkg::cpm_mode_t mode_o;
  cpm_pkg::cpm_mode_t prev;
  int err_count = 0;
  int n_checks = 0;

  always #5 mclk_i = ~mclk_i;

  cpm_pin_host i_host (.cfg_i(cfg), .ac_coupled_i(ac), .pins_o(pins));
  cpm_mode_decoder i_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .pins_i(pins),
    .calibration_busy_i(cal), .bus_i(bus), .rdata_o(rdata_o), .mode_o(mode_o));

  function automatic cpm_pkg::cpm_mode_t exp_mode(cpm_pkg::cpm_pins_t p, logic c);
    cpm_pkg::cpm_mode_t m;
    m.cal_active = c;
    m.ext_mode = ~p.ece;
    m.diff_reset = ~p.style_single;
    m.fs_high = ~p.style_single | p.fsr_mid | p.fsr_level;
    m.ac_coupled = p.cmo_grounded;
    m.alt_ext_req = p.style_single & p.fsr_mid;
    m.resync = p.style_single ? p.resync_pos : p.resync_pos & ~p.fsr_level;
    m.fs_code = m.fs_high ? cpm_pkg::FS_CODE_HIGH : cpm_pkg::FS_CODE_LOW;
    if (m.ext_mode) begin
      m.fs_code = fs_exp;
    end
    return m;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_i);
    bus.wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a);
    @(posedge mclk_i);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge mclk_i);
    bus.rd <= 1'b0;
    #1 rd_val = rdata_o;
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------
  // tests
  // ---------------------------------------
  initial begin
    void'($urandom(32'ha237));
    repeat (4) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    bus_rd(cpm_pkg::ADDR_FS_ADJ);
    check(rd_val, {24'h0, cpm_pkg::FS_ADJ_RST});
    bus_rd(8'h08);
    check(rd_val, 32'h0);
    bus_wr(8'h08, 32'h0000_0011);
    bus_rd(cpm_pkg::ADDR_FS_ADJ);
    check(rd_val, {24'h0, cpm_pkg::FS_ADJ_RST});
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      prev = exp_mode(pins, cal);
      @(posedge mclk_i);
      if (i < 2) begin
        cfg <= (i == 0) ? 6'h00 : 6'h3f;
      end else begin
        cfg <= 6'($urandom);
      end
      ac <= 1'($urandom);
      cal <= 1'($urandom);
      repeat (2) @(posedge mclk_i);
      #1 check({31'h0, mode_o.ext_mode}, {31'h0, prev.ext_mode});
      repeat (2) @(posedge mclk_i);
      #1 check({17'h0, mode_o}, {17'h0, exp_mode(pins, cal)});
      rnd = $urandom;
      bus_wr(cpm_pkg::ADDR_FS_ADJ, rnd);
      if (!pins.ece) begin
        fs_exp = rnd[7:0];
      end
      bus_rd(cpm_pkg::ADDR_FS_ADJ);
      check(rd_val, {24'h0, fs_exp});
      bus_rd(cpm_pkg::ADDR_STATUS);
      check(rd_val, {17'h0, exp_mode(pins, cal)});
    end
    $display("test random done");
    @(posedge mclk_i);
    reset_n_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    fs_exp = cpm_pkg::FS_ADJ_RST;
    bus_rd(cpm_pkg::ADDR_FS_ADJ);
    check(rd_val, {24'h0, cpm_pkg::FS_ADJ_RST});
    repeat (cpm_pkg::SYNC_LAT) @(posedge mclk_i);
    #1 check({17'h0, mode_o}, {17'h0, exp_mode(pins, cal)});
    $display("test mid-run reset done");
    print_verdict();
  end

  initial begin
    #100us;
    err_count++;
    print_verdict();
  end
endmodule
`default_nettype wire

// ===== cpm_mode_decoder.sv
`timescale 1ns/10ps
`default_nettype none
module cpm_mode_decoder (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // configuration pins
  input wire cpm_pkg::cpm_pins_t pins_i,
  // calibration engine
  input wire logic calibration_busy_i,
  // register port
  input wire cpm_pkg::cpm_bus_req_t bus_i,
  output logic [31:0] rdata_o,
  // decoded modes
  output cpm_pkg::cpm_mode_t mode_o
);

  // -----------------------------------------
  // state
  // -----------------------------------------
  cpm_pkg::cpm_state_t st_r;
  cpm_pkg::cpm_state_t st_nxt;
  cpm_pkg::cpm_pins_t pin_s;
  logic ext_now;
  logic single_now;

  assign pin_s = st_r.sync2;
  assign ext_now = ~pin_s.ece;
  assign single_now = pin_s.style_single;
  assign rdata_o = st_r.rdata;
  assign mode_o = st_r.mode;

  // -----------------------------------------
  // helpers
  // -----------------------------------------
  function automatic logic addr_hit(
    input logic [7:0] addr,
    input logic [7:0] off
  );
    addr_hit = (addr == off);
  endfunction

  function automatic logic [7:0] pin_fs_code(
    input logic high
  );
    pin_fs_code = high ? cpm_pkg::FS_CODE_HIGH : cpm_pkg::FS_CODE_LOW;
  endfunction

  // -----------------------------------------
  // next state
  // -----------------------------------------
  always_comb begin
    st_nxt = st_r;
    // first stage feeds only the second
    st_nxt.sync1 = pins_i;
    st_nxt.sync2 = st_r.sync1;

    st_nxt.mode.cal_active = calibration_busy_i;

    // dedicated pin alone decides, the shared pin request is only reported
    st_nxt.mode.ext_mode = ext_now;

    st_nxt.mode.diff_reset = ~single_now;
    st_nxt.mode.alt_ext_req = single_now & pin_s.fsr_mid;

    if (single_now) begin
      st_nxt.mode.resync = pin_s.resync_pos;
      // a mid level on the shared pin is the extended request, range stays high
      st_nxt.mode.fs_high = pin_s.fsr_level | pin_s.fsr_mid;
    end else begin
      st_nxt.mode.resync = pin_s.resync_pos & ~pin_s.fsr_level;
      st_nxt.mode.fs_high = 1'b1;
    end

    if (ext_now) begin
      st_nxt.mode.fs_code = st_r.fs_adj;
    end else begin
      st_nxt.mode.fs_code = pin_fs_code(st_nxt.mode.fs_high);
    end

    st_nxt.mode.ac_coupled = pin_s.cmo_grounded;

    // register writes
    if (bus_i.wr && ext_now && addr_hit(bus_i.addr, cpm_pkg::ADDR_FS_ADJ)) begin
      st_nxt.fs_adj = bus_i.wdata[7:0];
    end

    // read data stands one cycle after the strobe only
    st_nxt.rdata = 32'h0000_0000;
    if (bus_i.rd) begin
      if (addr_hit(bus_i.addr, cpm_pkg::ADDR_FS_ADJ)) begin
        st_nxt.rdata = {24'h00_0000, st_r.fs_adj};
      end else if (addr_hit(bus_i.addr, cpm_pkg::ADDR_STATUS)) begin
        st_nxt.rdata = {{(32 - cpm_pkg::MODE_W){1'b0}}, st_r.mode};
      end else begin
        st_nxt.rdata = 32'h0000_0000;
      end
    end
  end

  // -----------------------------------------
  // registers
  // -----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
      st_r.fs_adj <= cpm_pkg::FS_ADJ_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // -----------------------------------------
  // assertions
  // -----------------------------------------
  // a sampled reset_n_i in the antecedent skips the release edge, state is still clear there
  a_cal_follows_busy: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    (reset_n_i && calibration_busy_i) |=> mode_o.cal_active
  ) else $error("calibration flag not raised while busy");

  a_cal_drops_idle: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    !calibration_busy_i |=> !mode_o.cal_active
  ) else $error("calibration flag high while idle");

  a_pin_only_mode: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    pin_s.ece |=> !mode_o.ext_mode
      && mode_o.fs_code == pin_fs_code(mode_o.fs_high)
  ) else $error("extended mode active with select pin high");

  a_ext_mode_on: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    (reset_n_i && !pin_s.ece) |=> mode_o.ext_mode && mode_o.fs_code == $past(st_r.fs_adj)
  ) else $error("extended mode not taken from registers");

  a_ece_priority: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    (pin_s.ece && single_now && pin_s.fsr_mid) |=>
      (mode_o.alt_ext_req && !mode_o.ext_mode)
  ) else $error("shared pin overrode dedicated select");

  a_single_resync: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    single_now |=> !mode_o.diff_reset
      && mode_o.resync == $past(pin_s.resync_pos)
      && mode_o.fs_high == $past(pin_s.fsr_level | pin_s.fsr_mid)
  ) else $error("single-ended resync decode wrong");

  a_diff_resync: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    (reset_n_i && !single_now) |=> mode_o.diff_reset
      && mode_o.resync == $past(pin_s.resync_pos & ~pin_s.fsr_level)
  ) else $error("differential resync decode wrong");

  a_diff_fs_high: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    mode_o.diff_reset |-> mode_o.fs_high
  ) else $error("differential mode lost high full scale");

  a_fs_write_ok: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    (reset_n_i && bus_i.wr && !pin_s.ece && bus_i.addr == cpm_pkg::ADDR_FS_ADJ) |=>
      st_r.fs_adj == $past(bus_i.wdata[7:0])
  ) else $error("adjust write lost in extended mode");

  a_fs_write_gate: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    pin_s.ece |=> $stable(st_r.fs_adj)
  ) else $error("adjust register changed in pin mode");

  a_ac_select: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    ##1 mode_o.ac_coupled == $past(pin_s.cmo_grounded)
  ) else $error("ac coupling select wrong");

  a_alt_request: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    ##1 mode_o.alt_ext_req == $past(single_now && pin_s.fsr_mid)
  ) else $error("alternate extended request wrong");

  a_sync_latency: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    ($past(reset_n_i, 1) && $past(reset_n_i, 2) && $past(reset_n_i, 3))
      |-> mode_o.ext_mode == !$past(pins_i.ece, 3)
  ) else $error("select pin not seen after three cycles");

  a_read_timing: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    (reset_n_i && bus_i.rd && bus_i.addr == cpm_pkg::ADDR_FS_ADJ) |=>
      rdata_o == {24'h00_0000, $past(st_r.fs_adj)}
  ) else $error("adjust readback wrong");

  a_read_idle: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    !bus_i.rd |=> rdata_o == 32'h0000_0000
  ) else $error("read data outside read cycle");

  // -----------------------------------------
  // decode corners and register bus
  // -----------------------------------------
  a_reset_clears: assert property (
    @(posedge mclk_i)
    !reset_n_i |=> mode_o == '0 && rdata_o == 32'h0000_0000
      && st_r.fs_adj == cpm_pkg::FS_ADJ_RST
  ) else $error("state not cleared by reset");

  a_sync_stage_one: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    reset_n_i |=> st_r.sync1 == $past(pins_i)
  ) else $error("first synchroniser stage missed the pins");

  a_sync_stage_two: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    reset_n_i |=> st_r.sync2 == $past(st_r.sync1)
  ) else $error("second synchroniser stage skipped");

  a_pin_fs_low: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    (reset_n_i && pin_s.ece && single_now && !pin_s.fsr_level && !pin_s.fsr_mid) |=>
      (!mode_o.fs_high && mode_o.fs_code == cpm_pkg::FS_CODE_LOW)
  ) else $error("low full scale not selected by pin");

  a_pin_fs_high: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    (reset_n_i && pin_s.ece && single_now && pin_s.fsr_level) |=>
      mode_o.fs_code == cpm_pkg::FS_CODE_HIGH
  ) else $error("high full scale not selected by pin");

  a_diff_fs_code: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    (reset_n_i && pin_s.ece && !single_now) |=>
      mode_o.fs_code == cpm_pkg::FS_CODE_HIGH
  ) else $error("differential mode took full scale from pin");

  a_diff_neg_leg: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    (reset_n_i && !single_now && pin_s.fsr_level) |=> !mode_o.resync
  ) else $error("differential resync ignored negative leg");

  a_alt_blocked: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    (reset_n_i && !single_now) |=> !mode_o.alt_ext_req
  ) else $error("shared pin request seen in differential mode");

  a_alt_keeps_high: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    (reset_n_i && single_now && pin_s.fsr_mid) |=> (mode_o.alt_ext_req && mode_o.fs_high)
  ) else $error("mid level request lost or dropped range");

  a_dc_coupled: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    (reset_n_i && !pin_s.cmo_grounded) |=> !mode_o.ac_coupled
  ) else $error("ac coupling without grounded pin");

  a_fs_hold_idle: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    (reset_n_i && !bus_i.wr) |=> $stable(st_r.fs_adj)
  ) else $error("adjust register changed without a write");

  a_fs_wr_other: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    (reset_n_i && bus_i.wr && bus_i.addr != cpm_pkg::ADDR_FS_ADJ) |=>
      $stable(st_r.fs_adj)
  ) else $error("write to another address hit the adjust register");

  a_status_read: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    (reset_n_i && bus_i.rd && bus_i.addr == cpm_pkg::ADDR_STATUS) |=>
      rdata_o == {{(32 - cpm_pkg::MODE_W){1'b0}}, $past(mode_o)}
  ) else $error("status readback wrong");

  a_unmapped_read: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    (reset_n_i && bus_i.rd && bus_i.addr != cpm_pkg::ADDR_FS_ADJ
      && bus_i.addr != cpm_pkg::ADDR_STATUS) |=> rdata_o == 32'h0000_0000
  ) else $error("unmapped read returned data");

  a_ext_write_seen: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    (reset_n_i && bus_i.wr && !pin_s.ece && bus_i.addr == cpm_pkg::ADDR_FS_ADJ)
      ##1 !pin_s.ece |=> mode_o.fs_code == $past(bus_i.wdata[7:0], 2)
  ) else $error("written adjust code not applied");

  a_ext_code_held: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    (reset_n_i && !pin_s.ece && !bus_i.wr) ##1 (reset_n_i && !pin_s.ece) |=>
      $stable(mode_o.fs_code)
  ) else $error("extended code moved without a write");

endmodule
`default_nettype wire

// ===== cpm_pin_host.sv
`timescale 1ns/10ps
`default_nettype none
module cpm_pin_host (
  // requested pin levels
  input wire cpm_pkg::cpm_pins_t cfg_i,
  input wire logic ac_coupled_i,
  // pins to the device
  output cpm_pkg::cpm_pins_t pins_o
);
  always_comb begin
    pins_o = cfg_i;
    // board grounds the common mode pin whenever the inputs are ac coupled
    pins_o.cmo_grounded = ac_coupled_i;
  end
endmodule
`default_nettype wire

// ===== cpm_pkg.sv
`default_nettype none
package cpm_pkg;
  // -----------------------------------------
  // register map and reset values
  // -----------------------------------------
  localparam logic [7:0] ADDR_FS_ADJ = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] FS_CODE_LOW = 8'h40;
  localparam logic [7:0] FS_CODE_HIGH = 8'hc0;
  localparam logic [7:0] FS_ADJ_RST = FS_CODE_HIGH;
  localparam int SYNC_STAGES = 2;
  localparam int SYNC_LAT = SYNC_STAGES + 1;

  // -----------------------------------------
  // carriers
  // -----------------------------------------
  typedef struct packed {
    logic ece;
    logic style_single;
    logic fsr_level;
    logic fsr_mid;
    logic resync_pos;
    logic cmo_grounded;
  } cpm_pins_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } cpm_bus_req_t;

  typedef struct packed {
    logic cal_active;
    logic ext_mode;
    logic diff_reset;
    logic fs_high;
    logic ac_coupled;
    logic alt_ext_req;
    logic resync;
    logic [7:0] fs_code;
  } cpm_mode_t;

  localparam int MODE_W = $bits(cpm_mode_t);

  typedef struct packed {
    cpm_pins_t sync1;
    cpm_pins_t sync2;
    cpm_mode_t mode;
    logic [7:0] fs_adj;
    logic [31:0] rdata;
  } cpm_state_t;
endpackage
`default_nettype wire
